// File: shared/cmbuf_consts.svh
`ifndef CMBUF_CONSTS_SVH
`define CMBUF_CONSTS_SVH
`define CMBUF_WORD_W        16
`define CMBUF_BOARD_WORDS   4096
`define CMBUF_MAX_WORDS     32768
`define CMBUF_ADDR_W        15
`define CMBUF_LOCAL_W       12
`define CMBUF_X_W           6
`define CMBUF_Y_W           6
`define CMBUF_BOARD_W       3
`define CMBUF_BOARD_DEF     3'h0
`define CMBUF_CLK_NS        25
`define CMBUF_CYC_SHORT_NS  800
`define CMBUF_CYC_LONG_NS   1600
`define CMBUF_FIFO_DEPTH    32
`define CMBUF_ZERO_WORD     16'h0000
`define CMBUF_ZERO_ADDR     15'h0000
`define CMBUF_ZERO_CNT      7'h00
`define CMBUF_CNT_W         7
`endif

// File: shared/cmbuf_pkg.sv
`include "cmbuf_consts.svh"
package cmbuf_pkg;
    typedef logic [`CMBUF_WORD_W-1:0] cmbuf_word_t;
    typedef enum logic [1:0] {
        CMBUF_IDLE  = 2'h0,
        CMBUF_READ  = 2'h1,
        CMBUF_WRITE = 2'h2
    } cmbuf_phase_t;
    typedef struct packed {
        logic read_current_phase_one;
        logic read_current_phase_two;
        logic sense_sample;
        logic buffer_capture_pulse;
        logic write_suppress;
        logic address_capture_pulse;
        logic buffer_zero_pulse;
        logic with_accumulator;
    } cmbuf_ctl_t;
    typedef struct packed {
        logic bus_capture_en;
        logic bus_output_en;
        logic out_transfer_a;
        logic return_path_block;
    } cmbuf_io_t;
    typedef struct packed {
        logic [`CMBUF_X_W-1:0] x_sel_idx;
        logic [`CMBUF_Y_W-1:0] y_sel_idx;
        logic                  board_hit;
    } cmbuf_sel_t;
endpackage

// File: hdl/cmbuf_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module cmbuf_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;
    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem[rd_r];
    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_r] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// File: hdl/cmbuf_core.sv
// Contract
// RULE_01: board holds 4096 16-bit words; boards stack up to 32768 words.
// RULE_02: address holder decodes into X and Y select; it only holds.
// RULE_03: before a write, data holder captures the write source bus word.
// RULE_04: each data bit drives its own write-suppress flip-flop in write phase.
// RULE_05: on read, sense outputs set data holder bits unconditionally; here only while the readback FIFO has room (rb_ready).
// RULE_06: data holder drives readback bus to processor, state logic, display.
// RULE_07: bus capture enable loads data holder from the io data bus.
// RULE_08: bus output enable drives data holder onto io bus; otherwise undriven.
// RULE_09: processor timing makes every memory control pulse.
// RULE_10: io command signals valid together with the data word.
// RULE_11: reference cycle 0.8 us without, 1.6 us with accumulator.
// RULE_12: return path block stops data holder driving the readback bus; words already in the readback FIFO still drain out.
// RULE_13: io data bus is 16 bits wide.
// RULE_14: buffer zero clears all data bits before the sense sample.
`timescale 1ns/100ps
`default_nettype none
`include "cmbuf_consts.svh"
module cmbuf_core
    import cmbuf_pkg::*;
#(
    parameter int                      WORD_W   = `CMBUF_WORD_W,
    parameter int                      FIFO_DEP = `CMBUF_FIFO_DEPTH,
    parameter logic [`CMBUF_BOARD_W-1:0] BOARD_ID = `CMBUF_BOARD_DEF
) (
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_n_i,
    input  wire cmbuf_ctl_t               ctl_i,
    input  wire cmbuf_io_t                io_i,
    input  wire logic [`CMBUF_ADDR_W-1:0] addr_i,
    input  wire cmbuf_word_t              write_source_bus_i,
    input  wire cmbuf_word_t              sense_i,
    input  wire cmbuf_word_t              io_data_i,
    output cmbuf_word_t                   io_data_o,
    output logic                          io_data_oe_n_o,
    output cmbuf_word_t                   readback_o,
    output logic                          readback_valid_o,
    input  wire logic                     readback_ready_i,
    output cmbuf_sel_t                    sel_o,
    output cmbuf_word_t                   suppress_o,
    output logic                          cycle_busy_o,
    output logic                          cycle_overrun_o
);
    localparam int SHORT_CYC = `CMBUF_CYC_SHORT_NS / `CMBUF_CLK_NS;
    localparam int LONG_CYC  = `CMBUF_CYC_LONG_NS / `CMBUF_CLK_NS;

    typedef struct packed {
        logic [`CMBUF_ADDR_W-1:0] core_address_holder;
        cmbuf_word_t              core_data_holder;
        cmbuf_word_t              suppress;
        cmbuf_phase_t             phase;
        logic [`CMBUF_CNT_W-1:0]  cnt;
        logic                     long_cyc;
        logic                     zeroed;
        logic                     overrun;
        logic                     drive_io;
    } cmbuf_state_t;

    cmbuf_state_t st_r;
    cmbuf_state_t st_nxt;
    logic         rb_ready;
    logic [`CMBUF_CNT_W-1:0] limit;

    // readback path is buffered; once a stalled consumer fills it, new sense samples are dropped
    cmbuf_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEP)
    ) u_readback_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (st_r.core_data_holder),
        .in_valid_i  (st_r.phase == CMBUF_READ && !io_i.return_path_block), // RULE_06 RULE_12
        .in_ready_o  (rb_ready),
        .out_data_o  (readback_o),
        .out_valid_o (readback_valid_o),
        .out_ready_i (readback_ready_i)
    );

    // the idle edge is the cycle's last one, so the count stops one short
    assign limit = st_r.long_cyc ? `CMBUF_CNT_W'(LONG_CYC - 1)
                                 : `CMBUF_CNT_W'(SHORT_CYC - 1); // RULE_11

    always_comb begin
        st_nxt = st_r;
        if (ctl_i.address_capture_pulse) begin
            st_nxt.core_address_holder = addr_i; // RULE_02
            st_nxt.phase    = CMBUF_IDLE;
            st_nxt.cnt      = `CMBUF_ZERO_CNT;
            st_nxt.long_cyc = ctl_i.with_accumulator;
            st_nxt.zeroed   = 1'b0;
            // an old cycle ending on this edge still reports its overrun
            st_nxt.overrun  = (st_r.cnt >= limit) && (st_r.phase != CMBUF_IDLE);
        end else if (st_r.cnt < limit) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else begin
            st_nxt.overrun = st_r.phase != CMBUF_IDLE; // RULE_11
            st_nxt.phase   = CMBUF_IDLE;
        end
        if (ctl_i.read_current_phase_one || ctl_i.read_current_phase_two) begin // RULE_09
            st_nxt.phase = CMBUF_READ;
        end
        if (ctl_i.buffer_zero_pulse) begin
            st_nxt.core_data_holder = `CMBUF_ZERO_WORD; // RULE_14
            st_nxt.zeroed = 1'b1;
        end else if (ctl_i.sense_sample && rb_ready) begin
            // or-in: bits only set, zero pulse already cleared the word
            st_nxt.core_data_holder = st_r.core_data_holder | sense_i; // RULE_05 RULE_14
        end else if (ctl_i.buffer_capture_pulse) begin
            st_nxt.core_data_holder = write_source_bus_i; // RULE_03
            st_nxt.phase = CMBUF_WRITE;
        end else if (io_i.bus_capture_en) begin
            st_nxt.core_data_holder = io_data_i; // RULE_07 RULE_13
        end
        if (ctl_i.write_suppress) begin
            // a zero bit blocks storage at that position
            for (int b = 0; b < WORD_W; b++) begin
                st_nxt.suppress[b] = ~st_r.core_data_holder[b]; // RULE_04
            end
        end else begin
            st_nxt.suppress = `CMBUF_ZERO_WORD;
        end
        st_nxt.drive_io = io_i.bus_output_en; // RULE_08 RULE_10
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_r.core_address_holder <= `CMBUF_ZERO_ADDR;
            st_r.core_data_holder    <= `CMBUF_ZERO_WORD;
            st_r.suppress            <= `CMBUF_ZERO_WORD;
            st_r.phase               <= CMBUF_IDLE;
            st_r.cnt                 <= `CMBUF_ZERO_CNT;
            st_r.long_cyc            <= 1'b0;
            st_r.zeroed              <= 1'b0;
            st_r.overrun             <= 1'b0;
            st_r.drive_io            <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // 4096-word board: 6+6 bits X/Y, top 3 bits pick the board
    assign sel_o.x_sel_idx = st_r.core_address_holder[`CMBUF_X_W-1:0]; // RULE_01 RULE_02
    assign sel_o.y_sel_idx = st_r.core_address_holder[`CMBUF_LOCAL_W-1:`CMBUF_X_W];
    assign sel_o.board_hit = st_r.core_address_holder[`CMBUF_ADDR_W-1:`CMBUF_LOCAL_W] == BOARD_ID;
    assign suppress_o      = st_r.suppress;
    assign io_data_o       = st_r.core_data_holder;
    assign io_data_oe_n_o  = ~st_r.drive_io; // RULE_08
    assign cycle_busy_o    = st_r.phase != CMBUF_IDLE;
    assign cycle_overrun_o = st_r.overrun;

    a_write_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE_03
        ctl_i.buffer_capture_pulse && !ctl_i.buffer_zero_pulse && !ctl_i.sense_sample
        |=> st_r.core_data_holder == $past(write_source_bus_i))
        else $error("write word not captured");
    a_zero_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE_14
        ctl_i.buffer_zero_pulse |=> io_data_o == `CMBUF_ZERO_WORD)
        else $error("zero pulse did not clear");
    a_sense_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE_05
        ctl_i.sense_sample && rb_ready && !ctl_i.buffer_zero_pulse
        |=> (io_data_o & $past(sense_i)) == $past(sense_i))
        else $error("sense bit not set");
    a_io_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE_07
        io_i.bus_capture_en && !ctl_i.buffer_zero_pulse && !ctl_i.sense_sample
        && !ctl_i.buffer_capture_pulse |=> io_data_o == $past(io_data_i))
        else $error("io word not captured");
    a_io_drive: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE_08
        ##1 io_data_oe_n_o == !$past(io_i.bus_output_en))
        else $error("io drive enable wrong");
    a_suppress_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE_04
        ctl_i.write_suppress |=> suppress_o == ~$past(st_r.core_data_holder))
        else $error("suppress bits wrong");
    a_addr_decode: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE_02
        ctl_i.address_capture_pulse |=> {sel_o.y_sel_idx, sel_o.x_sel_idx}
        == $past(addr_i[`CMBUF_LOCAL_W-1:0]))
        else $error("select decode wrong");
    a_block_rb: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE_12
        io_i.return_path_block && readback_valid_o == 1'b0 |=> readback_valid_o == 1'b0)
        else $error("readback while blocked");
    a_cycle_end: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE_11
        $rose(cycle_busy_o) |-> ##[1:64] !cycle_busy_o)
        else $error("cycle too long");
endmodule
`default_nettype wire

// File: tb/cmbuf_proc_model.sv
`timescale 1ns/100ps
`default_nettype none
module cmbuf_proc_model
    import cmbuf_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire cmbuf_word_t dev_data_i,
    input  wire logic        dev_oe_n_i,
    output cmbuf_ctl_t       ctl_o,
    output cmbuf_io_t        io_o,
    output cmbuf_word_t      wire_o
);
    cmbuf_word_t drv_w;
    logic        drv_en;
    cmbuf_word_t last_w;
    initial begin
        ctl_o  = '0;
        io_o   = '0;
        drv_w  = 16'h0000;
        drv_en = 1'b0;
        last_w = 16'h0000;
    end
    // released bus shows a toggling pattern: the last word inverted, then the last word again
    always_comb begin
        if (!dev_oe_n_i) wire_o = dev_data_i;
        else if (drv_en) wire_o = drv_w;
        else wire_o = ~last_w;
    end
    always_ff @(posedge sys_clk_i) begin
        last_w <= wire_o;
    end
    task automatic pulse(input logic [7:0] c);
        @(negedge sys_clk_i) ctl_o = c;
        @(negedge sys_clk_i) ctl_o = '0;
    endtask
    // command and data word share the same cycle
    task automatic bus_in(input cmbuf_word_t w);
        @(negedge sys_clk_i);
        drv_w = w;
        drv_en = 1'b1;
        io_o.bus_capture_en = 1'b1;
        io_o.out_transfer_a = 1'b1;
        @(negedge sys_clk_i);
        drv_en = 1'b0;
        io_o.bus_capture_en = 1'b0;
        io_o.out_transfer_a = 1'b0;
    endtask
    // level controls; the out command rides with the output enable
    task automatic levels(input logic blk, input logic drv);
        @(negedge sys_clk_i);
        io_o.return_path_block = blk;
        io_o.bus_output_en = drv;
        io_o.out_transfer_a = drv;
    endtask
endmodule
`default_nettype wire

// File: tb/test_cmbuf_core.sv
`timescale 1ns/100ps
`default_nettype none
module test_cmbuf_core;
    import cmbuf_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n;
    logic [14:0] addr;
    cmbuf_word_t wsb;
    cmbuf_word_t sense;
    logic        rb_rdy;
    cmbuf_ctl_t  ctl;
    cmbuf_io_t   io;
    cmbuf_word_t bus_w, io_q, rb_w, sup;
    logic        oe_n, rb_v, busy, ovr;
    cmbuf_sel_t  sel;
    int          n_errors = 0;
    int          total_checks = 0;
    int          n;
    always #12.5 sys_clk = ~sys_clk;
    cmbuf_proc_model i_cmbuf_proc_model (.sys_clk_i(sys_clk), .dev_data_i(io_q),
        .dev_oe_n_i(oe_n), .ctl_o(ctl), .io_o(io), .wire_o(bus_w));
    cmbuf_core i_cmbuf_core (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .ctl_i(ctl), .io_i(io),
        .addr_i(addr), .write_source_bus_i(wsb), .sense_i(sense), .io_data_i(bus_w),
        .io_data_o(io_q), .io_data_oe_n_o(oe_n), .readback_o(rb_w),
        .readback_valid_o(rb_v), .readback_ready_i(rb_rdy), .sel_o(sel),
        .suppress_o(sup), .cycle_busy_o(busy), .cycle_overrun_o(ovr));
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic read_fill_drain;
        sense = 16'h9c63;
        // long cycle keeps the read phase open past the FIFO depth
        i_cmbuf_proc_model.pulse(8'h05);
        i_cmbuf_proc_model.pulse(8'h02);
        i_cmbuf_proc_model.pulse(8'h20);
        check_word(io_q, 16'h9c63);
        i_cmbuf_proc_model.pulse(8'h40);
        repeat (40) @(negedge sys_clk);
        check_word({15'h0, rb_v}, 16'h0001);
        sense = 16'h0f0f;
        i_cmbuf_proc_model.pulse(8'h20);
        check_word(io_q, 16'h9c63);
        i_cmbuf_proc_model.levels(1'b1, 1'b0);
        repeat (2) @(negedge sys_clk);
        rb_rdy = 1'b1;
        n = 0;
        // look before each edge: the head word pops on the edge that follows
        repeat (40) begin
            if (rb_v === 1'b1) begin
                n++;
                check_word(rb_w, 16'h9c63);
            end
            @(negedge sys_clk);
        end
        check_word(16'(n), 16'h0020);
        i_cmbuf_proc_model.levels(1'b0, 1'b0);
    endtask
    task automatic write_path;
        wsb = 16'ha50f;
        i_cmbuf_proc_model.pulse(8'h10);
        check_word(io_q, 16'ha50f);
        i_cmbuf_proc_model.pulse(8'h08);
        check_word(sup, 16'h5af0);
    endtask
    task automatic io_path;
        i_cmbuf_proc_model.bus_in(16'h5a3c);
        check_word(io_q, 16'h5a3c);
        i_cmbuf_proc_model.levels(1'b0, 1'b1);
        @(negedge sys_clk);
        check_word({15'h0, oe_n}, 16'h0000);
        check_word(bus_w, 16'h5a3c);
        i_cmbuf_proc_model.levels(1'b0, 1'b0);
        @(negedge sys_clk);
        check_word({15'h0, oe_n}, 16'h0001);
    endtask
    task automatic ref_cycle(input logic [14:0] a, input logic [7:0] c,
                             input logic [15:0] s, input logic [15:0] len);
        addr = a;
        i_cmbuf_proc_model.pulse(c);
        check_word(16'(sel), s);
        check_word({15'h0, ovr}, 16'h0000);
        n = 0;
        while (busy === 1'b1 && n < 100) begin
            n++;
            @(negedge sys_clk);
        end
        check_word(16'(n), len);
        check_word({15'h0, ovr}, 16'h0001);
    endtask
    initial begin
        rst_n  = 1'b0;
        addr   = 15'h0000;
        wsb    = 16'h0000;
        sense  = 16'h0000;
        rb_rdy = 1'b0;
        repeat (12) @(negedge sys_clk);
        check_word({15'h0, oe_n}, 16'h0001);
        check_word(io_q, 16'h0000);
        rst_n = 1'b1;
        read_fill_drain();
        write_path();
        io_path();
        ref_cycle(15'h0ad5, 8'h84, 16'h0ad7, 16'h0020);
        ref_cycle(15'h5ad5, 8'h85, 16'h0ad6, 16'h0040);
        complete_run();
    end
    // run needs well under 1000 cycles
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
